// ---- hw/pwr_lpi_ctrl.sv ----
// Power-mode, energy-detect and low-power-idle controller with AHB-Lite registers
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module pwr_lpi_ctrl #(
  parameter int unsigned TICK_CYC = pwr_pkg::GO_SLEEP_TICK_US * pwr_pkg::CLK_MHZ,
  parameter int unsigned LINK_PERIOD_CYC = pwr_pkg::LINK_PERIOD_MS * 1000 * pwr_pkg::CLK_MHZ,
  parameter int unsigned REFRESH_PERIOD_CYC = pwr_pkg::REFRESH_PERIOD_US * pwr_pkg::CLK_MHZ,
  parameter int unsigned REFRESH_CYC = pwr_pkg::REFRESH_US * pwr_pkg::CLK_MHZ
)(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [31:0] O_HRDATA,
  // Power controls
  input wire logic I_ENERGY,
  output logic O_PLL_EN,
  output logic O_MAC_EN,
  output logic O_HOST_EN,
  output logic O_PHY_EN,
  output logic O_ED_ONLY,
  output logic [3:0] O_PORT_PD,
  output logic O_LINK_PULSE,
  output logic O_SOFT_RST,
  output logic O_CLK_GATE,
  // MAC side
  input wire pwr_pkg::mii_t I_MAC_TX,
  output pwr_pkg::mii_t O_MAC_RX,
  output logic O_MAC_CRS,
  output logic O_MAC_TX_OK,
  // PHY side
  input wire pwr_pkg::mii_t I_PHY_RX,
  output pwr_pkg::mii_t O_PHY_TX,
  output logic O_PARTNER_LOW_POWER,
  output logic [2:0] O_LINE_STATE
);

  function automatic logic is_lpi(input pwr_pkg::mii_t m);
    is_lpi = (m == pwr_pkg::MII_LPI);
  endfunction

  function automatic logic hit(input logic [31:0] cnt, input int unsigned lim);
    hit = (cnt == 32'(lim - 1));
  endfunction

  logic soft_rst_reg;
  logic rst;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [1:0] mode_reg;
  logic [7:0] go_sleep_reg;
  logic [3:0] port_pd_reg;
  logic [3:0] phy_pd_reg;
  logic lpi_req_reg;
  logic ed_low_reg;
  logic ed_low_next;
  logic [31:0] tick_cnt_reg;
  logic [31:0] tick_cnt_next;
  logic [8:0] idle_cnt_reg;
  logic [8:0] idle_cnt_next;
  logic [31:0] pulse_cnt_reg;
  logic [31:0] pulse_cnt_next;
  logic plp_reg;
  pwr_pkg::tx_t tx_reg;
  pwr_pkg::tx_t tx_next;
  logic [31:0] rcv_cnt_reg;
  logic [31:0] rcv_cnt_next;
  pwr_pkg::line_t line_reg;
  pwr_pkg::line_t line_next;
  logic [31:0] line_cnt_reg;
  logic [31:0] line_cnt_next;

  // Bus decode
  wire acc = I_HSEL & I_HTRANS[1] & I_HREADY;
  wire wake = acc & (mode_reg == pwr_pkg::MODE_SOFT_PD);
  wire [7:0] ra = I_HADDR[7:0];
  wire [31:0] stat_val = {25'h0, 3'(line_reg), 1'b0, tx_reg == pwr_pkg::TX_LPI, plp_reg, ed_low_reg};
  wire [31:0] rd_val = (ra == pwr_pkg::OFF_MODE) ? 32'(mode_reg) << pwr_pkg::MODE_LSB :
                       (ra == pwr_pkg::OFF_SLEEP) ? {24'h0, go_sleep_reg} :
                       (ra == pwr_pkg::OFF_PORT_PD) ? {28'h0, port_pd_reg} :
                       (ra == pwr_pkg::OFF_PHY_PD) ? {28'h0, phy_pd_reg} :
                       (ra == pwr_pkg::OFF_EEE) ? {31'h0, lpi_req_reg} :
                       (ra == pwr_pkg::OFF_STAT) ? stat_val : 32'h0;
  wire [1:0] wr_mode = I_HWDATA[pwr_pkg::MODE_LSB +: 2];

  // Mode decode
  wire in_norm = (mode_reg == pwr_pkg::MODE_NORMAL);
  wire in_ed = (mode_reg == pwr_pkg::MODE_ED);
  wire in_pd = (mode_reg == pwr_pkg::MODE_SOFT_PD);

  // Go-sleep timer runs only in energy detect, normal state, no energy
  wire run = in_ed & ~ed_low_reg & ~I_ENERGY;
  wire tick = run & hit(tick_cnt_reg, TICK_CYC);
  wire go_low = run & (idle_cnt_reg > {1'b0, go_sleep_reg});

  // Transmit and line conditions
  wire tx_lpi = (tx_reg == pwr_pkg::TX_LPI);
  wire quiet_len_hit = hit(line_cnt_reg, REFRESH_PERIOD_CYC - REFRESH_CYC);

  assign rst = I_SYS_RST | soft_rst_reg;

  always_comb
  begin
    tick_cnt_next = (!run || tick) ? 32'h0 : tick_cnt_reg + 32'h1;
    idle_cnt_next = !run ? 9'h0 : (tick && idle_cnt_reg != 9'h1ff) ? idle_cnt_reg + 9'h1 : idle_cnt_reg;
    if (!in_ed)
      ed_low_next = 1'b0;
    else if (ed_low_reg)
      ed_low_next = ~I_ENERGY;
    else
      ed_low_next = go_low;
    pulse_cnt_next = (!in_ed || hit(pulse_cnt_reg, LINK_PERIOD_CYC)) ? 32'h0 : pulse_cnt_reg + 32'h1;
  end

  // Transmit low-power-idle path
  always_comb
  begin
    tx_next = tx_reg;
    rcv_cnt_next = 32'h0;
    case (tx_reg)
      pwr_pkg::TX_NORM:
      begin
        if (lpi_req_reg && !I_MAC_TX.en)
          tx_next = pwr_pkg::TX_LPI;
      end
      pwr_pkg::TX_LPI:
      begin
        if (!lpi_req_reg)
          tx_next = pwr_pkg::TX_RECOV;
      end
      pwr_pkg::TX_RECOV:
      begin
        rcv_cnt_next = rcv_cnt_reg + 32'h1;
        if (lpi_req_reg)
          tx_next = pwr_pkg::TX_LPI;
        else if (hit(rcv_cnt_reg, pwr_pkg::RECOV_CYC))
          tx_next = pwr_pkg::TX_NORM;
      end
      default:
        tx_next = pwr_pkg::TX_NORM;
    endcase
  end

  // Line signalling: sleep, quiet, refresh, wake
  always_comb
  begin
    line_next = line_reg;
    line_cnt_next = line_cnt_reg + 32'h1;
    case (line_reg)
      pwr_pkg::LN_NORMAL:
      begin
        line_cnt_next = 32'h0;
        if (tx_lpi)
          line_next = pwr_pkg::LN_SLEEP;
      end
      pwr_pkg::LN_SLEEP:
      begin
        if (hit(line_cnt_reg, pwr_pkg::SLEEP_SIG_CYC))
        begin
          line_next = pwr_pkg::LN_QUIET;
          line_cnt_next = 32'h0;
        end
      end
      pwr_pkg::LN_QUIET:
      begin
        if (!tx_lpi)
        begin
          line_next = pwr_pkg::LN_WAKE;
          line_cnt_next = 32'h0;
        end
        else if (quiet_len_hit)
        begin
          line_next = pwr_pkg::LN_REFRESH;
          line_cnt_next = 32'h0;
        end
      end
      pwr_pkg::LN_REFRESH:
      begin
        if (hit(line_cnt_reg, REFRESH_CYC))
        begin
          line_next = tx_lpi ? pwr_pkg::LN_QUIET : pwr_pkg::LN_WAKE;
          line_cnt_next = 32'h0;
        end
      end
      pwr_pkg::LN_WAKE:
      begin
        if (hit(line_cnt_reg, pwr_pkg::WAKE_SIG_CYC))
          line_next = pwr_pkg::LN_NORMAL;
      end
      default:
        line_next = pwr_pkg::LN_NORMAL;
    endcase
  end

  // Output next values
  wire tx_norm_next = (tx_next == pwr_pkg::TX_NORM);
  wire pd_all = in_pd;
  wire phy_on = in_norm | (in_ed & ~ed_low_next);
  wire rx_lpi = is_lpi(I_PHY_RX);
  wire pulse_on = in_ed & (pulse_cnt_reg < 32'(pwr_pkg::LINK_PULSE_CYC));
  wire [3:0] port_pd_next = port_pd_reg | phy_pd_reg | {4{pd_all}};
  wire pwr_pkg::mii_t phy_tx_next = (tx_next == pwr_pkg::TX_LPI) ? pwr_pkg::MII_LPI :
                                    tx_norm_next ? I_MAC_TX : pwr_pkg::MII_IDLE;
  wire pwr_pkg::mii_t mac_rx_next = rx_lpi ? pwr_pkg::MII_IDLE : I_PHY_RX;

  // Soft-reset pulse of one cycle, reset only by the hardware reset
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
      soft_rst_reg <= 1'b0;
    else
      soft_rst_reg <= wake & ~soft_rst_reg;
  end

  // Bus phase tracking
  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h0;
      O_HRDATA <= 32'h0;
    end
    else
    begin
      wr_pend_reg <= acc & I_HWRITE & ~wake;
      wr_addr_reg <= ra;
      O_HRDATA <= (acc && !I_HWRITE) ? rd_val : 32'h0;
    end
  end

  // Software registers
  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst)
    begin
      mode_reg <= pwr_pkg::MODE_RST;
      go_sleep_reg <= pwr_pkg::GO_SLEEP_RST;
      port_pd_reg <= pwr_pkg::PD_RST;
      phy_pd_reg <= pwr_pkg::PD_RST;
      lpi_req_reg <= 1'b0;
    end
    else if (wr_pend_reg)
    begin
      if (wr_addr_reg == pwr_pkg::OFF_MODE && wr_mode != pwr_pkg::MODE_RSVD)
        mode_reg <= wr_mode;
      if (wr_addr_reg == pwr_pkg::OFF_SLEEP)
        go_sleep_reg <= I_HWDATA[7:0];
      if (wr_addr_reg == pwr_pkg::OFF_PORT_PD)
        port_pd_reg <= I_HWDATA[3:0];
      if (wr_addr_reg == pwr_pkg::OFF_PHY_PD)
        phy_pd_reg <= I_HWDATA[3:0];
      if (wr_addr_reg == pwr_pkg::OFF_EEE)
        lpi_req_reg <= I_HWDATA[pwr_pkg::EEE_REQ_BIT];
    end
  end

  // Energy detect and state machines
  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst)
    begin
      ed_low_reg <= 1'b0;
      tick_cnt_reg <= 32'h0;
      idle_cnt_reg <= 9'h0;
      pulse_cnt_reg <= 32'h0;
      tx_reg <= pwr_pkg::TX_NORM;
      rcv_cnt_reg <= 32'h0;
      line_reg <= pwr_pkg::LN_NORMAL;
      line_cnt_reg <= 32'h0;
      plp_reg <= 1'b0;
    end
    else
    begin
      ed_low_reg <= ed_low_next;
      tick_cnt_reg <= tick_cnt_next;
      idle_cnt_reg <= idle_cnt_next;
      pulse_cnt_reg <= pulse_cnt_next;
      tx_reg <= tx_next;
      rcv_cnt_reg <= rcv_cnt_next;
      line_reg <= line_next;
      line_cnt_reg <= line_cnt_next;
      plp_reg <= rx_lpi;
    end
  end

  // Registered outputs
  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst)
    begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
      O_PLL_EN <= 1'b1;
      O_MAC_EN <= 1'b1;
      O_HOST_EN <= 1'b1;
      O_PHY_EN <= 1'b1;
      O_ED_ONLY <= 1'b0;
      O_PORT_PD <= 4'h0;
      O_LINK_PULSE <= 1'b0;
      O_SOFT_RST <= 1'b0;
      O_CLK_GATE <= 1'b0;
      O_MAC_RX <= pwr_pkg::MII_IDLE;
      O_MAC_CRS <= 1'b0;
      O_MAC_TX_OK <= 1'b1;
      O_PHY_TX <= pwr_pkg::MII_IDLE;
      O_PARTNER_LOW_POWER <= 1'b0;
      O_LINE_STATE <= 3'h0;
    end
    else
    begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
      O_PLL_EN <= in_norm;
      O_MAC_EN <= in_norm;
      O_HOST_EN <= in_norm & ~wake;
      O_PHY_EN <= phy_on & ~pd_all;
      O_ED_ONLY <= in_ed & ed_low_next;
      O_PORT_PD <= port_pd_next;
      O_LINK_PULSE <= pulse_on;
      O_SOFT_RST <= wake & ~soft_rst_reg;
      O_CLK_GATE <= (tx_next == pwr_pkg::TX_LPI) & rx_lpi;
      O_MAC_RX <= mac_rx_next;
      O_MAC_CRS <= ~tx_norm_next;
      O_MAC_TX_OK <= tx_norm_next;
      O_PHY_TX <= phy_tx_next;
      O_PARTNER_LOW_POWER <= rx_lpi;
      O_LINE_STATE <= 3'(line_next);
    end
  end

endmodule

`default_nettype wire

// ---- hw/pwr_pkg.sv ----
// Constants, field layouts and types for the power and low-power-idle controller
package pwr_pkg;
  // Clock rate
  localparam int unsigned CLK_MHZ = 250;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_SLEEP = 8'h04;
  localparam logic [7:0] OFF_PORT_PD = 8'h08;
  localparam logic [7:0] OFF_PHY_PD = 8'h0c;
  localparam logic [7:0] OFF_EEE = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  // Field positions
  localparam int MODE_LSB = 3;
  localparam int EEE_REQ_BIT = 0;
  localparam int ST_LOW_BIT = 0;
  localparam int ST_PLP_BIT = 1;
  localparam int ST_TXLPI_BIT = 2;
  localparam int ST_LINE_LSB = 4;
  localparam int NPORT = 4;
  // Power-mode encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ED = 2'h1;
  localparam logic [1:0] MODE_SOFT_PD = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  // Reset values
  localparam logic [1:0] MODE_RST = MODE_NORMAL;
  localparam logic [7:0] GO_SLEEP_RST = 8'h10;
  localparam logic [3:0] PD_RST = 4'h0;
  // Times in their own units
  localparam int unsigned LINK_PULSE_NS = 120;
  localparam int unsigned LINK_PERIOD_MS = 1000;
  localparam int unsigned GO_SLEEP_TICK_US = 1000;
  localparam int unsigned REFRESH_PERIOD_US = 20000;
  localparam int unsigned REFRESH_US = 200;
  localparam int unsigned SLEEP_SIG_NS = 2000;
  localparam int unsigned WAKE_SIG_NS = 2000;
  localparam int unsigned RECOV_NS = 1000;
  // Derived cycle counts, least times rounded up
  localparam int unsigned LINK_PULSE_CYC = (LINK_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLEEP_SIG_CYC = (SLEEP_SIG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_SIG_CYC = (WAKE_SIG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RECOV_CYC = (RECOV_NS * CLK_MHZ + 999) / 1000;
  // Media-independent interface nibble
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } mii_t;
  localparam mii_t MII_IDLE = '{en: 1'b0, er: 1'b0, d: 4'h0};
  localparam mii_t MII_LPI = '{en: 1'b0, er: 1'b1, d: 4'h1};
  // Transmit path and line states
  typedef enum logic [1:0] {TX_NORM, TX_LPI, TX_RECOV} tx_t;
  typedef enum logic [2:0] {LN_NORMAL, LN_SLEEP, LN_QUIET, LN_REFRESH, LN_WAKE} line_t;
endpackage

// ---- test/pwr_lpi_chk_sva.sv ----
// Port assertions for the power and low-power-idle controller
`timescale 1ns/10ps
`default_nettype none
module pwr_lpi_chk (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  // Watched inputs
  input wire logic I_ENERGY,
  input wire pwr_pkg::mii_t I_PHY_RX,
  // Watched outputs
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic O_PLL_EN,
  input wire logic O_MAC_EN,
  input wire logic O_PHY_EN,
  input wire logic O_ED_ONLY,
  input wire logic O_LINK_PULSE,
  input wire logic O_SOFT_RST,
  input wire pwr_pkg::mii_t O_PHY_TX,
  input wire logic O_MAC_CRS,
  input wire logic O_MAC_TX_OK,
  input wire logic O_PARTNER_LOW_POWER
);
  logic [7:0] plen_reg;
  logic [7:0] plen_next;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  // Length of the current link pulse
  assign plen_next = O_LINK_PULSE ? plen_reg + 8'h01 : 8'h00;
  always_ff @(posedge I_CLK_SYS)
  begin
    plen_reg <= I_SYS_RST ? 8'h00 : plen_next;
  end
  property p_bus_ok;
    O_HREADYOUT && !O_HRESP;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready");
  property p_low_off;
    O_ED_ONLY |-> !O_PLL_EN && !O_MAC_EN && !O_PHY_EN;
  endproperty
  a_low_off: assert property (p_low_off) else $error("circuits on in low power");
  property p_wake;
    O_ED_ONLY && I_ENERGY |=> !O_ED_ONLY;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on energy");
  // Pulse cut short by leaving energy detect is exempt
  property p_pulse;
    $fell(O_LINK_PULSE) && !O_PLL_EN && (O_PHY_EN || O_ED_ONLY) |-> plen_reg == 8'h1e;
  endproperty
  a_pulse: assert property (p_pulse) else $error("link pulse width wrong");
  property p_srst;
    O_SOFT_RST |=> !O_SOFT_RST ##[0:1] O_PLL_EN;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset not one cycle");
  property p_lpi_code;
    $rose(O_MAC_CRS) |-> O_PHY_TX == pwr_pkg::MII_LPI && !O_MAC_TX_OK;
  endproperty
  a_lpi_code: assert property (p_lpi_code) else $error("no assert code on defer");
  property p_tx_ok;
    O_MAC_TX_OK != O_MAC_CRS && (!O_MAC_CRS || !O_PHY_TX.en);
  endproperty
  a_tx_ok: assert property (p_tx_ok) else $error("transmit allowed while deferring");
  property p_plp;
    (I_PHY_RX == pwr_pkg::MII_LPI) |=> O_PARTNER_LOW_POWER;
  endproperty
  a_plp: assert property (p_plp) else $error("partner indication missing");
endmodule
bind pwr_lpi_ctrl pwr_lpi_chk pwr_lpi_chk_i (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_ENERGY(I_ENERGY),
  .I_PHY_RX(I_PHY_RX), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_PLL_EN(O_PLL_EN), .O_MAC_EN(O_MAC_EN),
  .O_PHY_EN(O_PHY_EN), .O_ED_ONLY(O_ED_ONLY), .O_LINK_PULSE(O_LINK_PULSE), .O_SOFT_RST(O_SOFT_RST),
  .O_PHY_TX(O_PHY_TX), .O_MAC_CRS(O_MAC_CRS), .O_MAC_TX_OK(O_MAC_TX_OK),
  .O_PARTNER_LOW_POWER(O_PARTNER_LOW_POWER));
`default_nettype wire

// ---- test/phy_peer.sv ----
// Link partner model: receive nibbles and cable energy
`timescale 1ns/10ps
`default_nettype none
module phy_peer (
  // Clock
  input wire logic i_clk,
  // Commands
  input wire logic i_lpi,
  input wire logic i_cable,
  // Line
  output pwr_pkg::mii_t o_rx,
  output logic o_energy
);
  logic [3:0] cnt_reg;
  initial
  begin
    cnt_reg = 4'h0;
    o_rx = pwr_pkg::MII_IDLE;
    o_energy = 1'b1;
  end
  // Idle data nibble changes every cycle
  always @(posedge i_clk)
  begin
    cnt_reg <= cnt_reg + 4'h1;
    o_energy <= i_cable;
    o_rx <= i_lpi ? pwr_pkg::MII_LPI : {2'b00, cnt_reg};
  end
endmodule
`default_nettype wire

// ---- test/test_power_mode_and_eee_lpi_control.sv ----
// Self-checking bench for the power and low-power-idle controller
`timescale 1ns/10ps
`default_nettype none
module test_power_mode_and_eee_lpi_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic cable = 1'b1;
  logic rx_lpi = 1'b0;
  pwr_pkg::mii_t mac_tx = pwr_pkg::MII_IDLE;
  pwr_pkg::mii_t mac_rx, phy_rx, phy_tx;
  logic rdy, resp, energy, pll, mac, host, phy, edo, pulse, srst, gate, crs, txok, plp;
  logic [31:0] rdata, d, a, b;
  logic [3:0] ppd;
  logic [2:0] line;
  int err_total = 0;
  int check_count = 0;
  int n;
  always #2 clk = ~clk;
  pwr_lpi_ctrl #(.TICK_CYC(4), .LINK_PERIOD_CYC(100), .REFRESH_PERIOD_CYC(60), .REFRESH_CYC(10)) pwr_lpi_ctrl_i (
    .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(rdy === 1'b1), .O_HREADYOUT(rdy), .O_HRESP(resp),
    .O_HRDATA(rdata), .I_ENERGY(energy), .O_PLL_EN(pll), .O_MAC_EN(mac), .O_HOST_EN(host), .O_PHY_EN(phy),
    .O_ED_ONLY(edo), .O_PORT_PD(ppd), .O_LINK_PULSE(pulse), .O_SOFT_RST(srst), .O_CLK_GATE(gate),
    .I_MAC_TX(mac_tx), .O_MAC_RX(mac_rx), .O_MAC_CRS(crs), .O_MAC_TX_OK(txok), .I_PHY_RX(phy_rx),
    .O_PHY_TX(phy_tx), .O_PARTNER_LOW_POWER(plp), .O_LINE_STATE(line));
  phy_peer phy_peer_i (.i_clk(clk), .i_lpi(rx_lpi), .i_cable(cable), .o_rx(phy_rx), .o_energy(energy));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ad};
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    d = rdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    bus(1'b1, ad, wd);
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0);
    chk("read", d, exp);
  endtask
  function automatic logic hit(input int s);
    case (s)
      0: hit = edo === 1'b1;
      1: hit = pulse === 1'b1;
      2: hit = line === 3'h3;
      3: hit = crs === 1'b0;
      4: hit = line === 3'h0;
      5: hit = line !== 3'h3;
      default: hit = line === 3'h4;
    endcase
  endfunction
  task automatic wt(input int s, input int lim);
    n = 0;
    while (!hit(s) && n < lim)
    begin
      tick(1);
      n++;
    end
    if (n >= lim)
      err_total++;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #40000;
    err_total++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(32'h2e611f18));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk("enables", {pll, mac, host, phy, txok, crs}, 6'h3e);
    rdchk(pwr_pkg::OFF_MODE, 32'h0);
    rdchk(pwr_pkg::OFF_SLEEP, 32'h10);
    rdchk(8'h1c, 32'h0);
    wr(pwr_pkg::OFF_MODE, 32'h18);
    rdchk(pwr_pkg::OFF_MODE, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      a = $urandom & 32'hf;
      b = $urandom & 32'hf;
      wr(pwr_pkg::OFF_PORT_PD, a);
      wr(pwr_pkg::OFF_PHY_PD, b);
      tick(2);
      chk("port pd", ppd, a | b);
    end
    rdchk(pwr_pkg::OFF_PHY_PD, b);
    wr(pwr_pkg::OFF_SLEEP, 32'h2);
    wr(pwr_pkg::OFF_MODE, 32'h08);
    tick(2);
    chk("ed", {pll, mac, host, phy}, 4'h1);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      cable <= ~cable;
      tick(4);
      chk("restart", edo, 1'b0);
    end
    @(posedge clk);
    cable <= 1'b0;
    wt(0, 100);
    chk("go sleep", n >= 12 && n < 24, 1'b1);
    chk("low", {pll, mac, phy, edo}, 4'h1);
    rdchk(pwr_pkg::OFF_STAT, 32'h1);
    wt(1, 200);
    chk("pulse", pulse, 1'b1);
    @(posedge clk);
    cable <= 1'b1;
    tick(3);
    chk("wake", {edo, phy}, 2'h1);
    wr(pwr_pkg::OFF_MODE, 32'h0);
    tick(2);
    chk("normal", {pll, mac, host, phy}, 4'hf);
    @(posedge clk);
    mac_tx <= {2'b10, 4'($urandom)};
    wr(pwr_pkg::OFF_EEE, 32'h1);
    tick(2);
    chk("frame", crs, 1'b0);
    @(posedge clk);
    mac_tx <= pwr_pkg::MII_IDLE;
    tick(3);
    chk("tx lpi", {phy_tx, crs, txok}, {pwr_pkg::MII_LPI, 2'b10});
    wt(2, 1000);
    wt(5, 100);
    chk("refresh", n, 10);
    wt(2, 100);
    chk("quiet", n, 50);
    @(posedge clk);
    rx_lpi <= 1'b1;
    tick(3);
    chk("rx lpi", {plp, mac_rx, gate}, {1'b1, pwr_pkg::MII_IDLE, 1'b1});
    wr(pwr_pkg::OFF_EEE, 32'h0);
    wt(6, 20);
    chk("recov", {phy_tx, crs}, {pwr_pkg::MII_IDLE, 1'b1});
    wt(3, 400);
    a = n;
    chk("recov len", a > 240 && a <= 250, 1'b1);
    wt(4, 600);
    chk("wake len", a + n, 500);
    chk("split", {txok, plp, gate}, 3'h6);
    rdchk(pwr_pkg::OFF_STAT, 32'h2);
    @(posedge clk);
    rx_lpi <= 1'b0;
    tick(3);
    chk("rx end", plp, 1'b0);
    chk("rx data", mac_rx, {2'b00, 4'(phy_rx.d - 4'h1)});
    wr(pwr_pkg::OFF_MODE, 32'h10);
    tick(2);
    chk("soft pd", {pll, mac, phy, ppd}, 7'h0f);
    rdchk(pwr_pkg::OFF_SLEEP, 32'h2);
    chk("soft rst", srst, 1'b1);
    tick(3);
    rdchk(pwr_pkg::OFF_SLEEP, 32'h10);
    rdchk(pwr_pkg::OFF_MODE, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
